// ---- pkg/eeprom_ctrl_pkg.sv ----
// Functional notes
// - key register is write-only, reads zero
// - control start write allowed only as the next access after key
// - permit bit required for any start
// - aborted cycle flag on pin/watchdog reset
// - skip-erase bit chooses erase before write
// - erase codes for 8, 4, 1 words
// - 0x4050 bulk erases whole array
// - write code 0001xx programs one word
// - last table write address is captured
// - captured low address bit 0 is zero
// - captured upper address bit 7 is zero
// - table reads return one 16-bit word
// - done flag set when an erase or write completes, not on abort
// - cycles run without stalling the host
// - array at 7FFE00h-7FFFFFh, 256 words
package eeprom_ctrl_pkg;
    localparam logic [11:0] CONTROL_OFFSET  = 12'h000;
    localparam logic [11:0] KEY_OFFSET      = 12'h004;
    localparam logic [11:0] TBLWR_OFFSET    = 12'h008;
    localparam logic [11:0] LATCH_OFFSET    = 12'h00C;
    localparam logic [11:0] TBLRD_OFFSET    = 12'h010;
    localparam logic [11:0] ADDR_OFFSET     = 12'h014;
    localparam logic [11:0] STATUS_OFFSET   = 12'h018;
    localparam int          START_BIT       = 15;
    localparam int          PERMIT_BIT      = 14;
    localparam int          ABORT_BIT       = 13;
    localparam int          SKIP_ERASE_BIT  = 12;
    localparam int          ERASE_SEL_BIT   = 6;
    localparam logic [15:0] CONTROL_WMASK   = 16'h507F;
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [7:0]  KEY_FIRST       = 8'h55;
    localparam logic [7:0]  KEY_SECOND      = 8'hAA;
    localparam logic [5:0]  OP_ERASE8       = 6'h1A;
    localparam logic [5:0]  OP_ERASE4       = 6'h19;
    localparam logic [5:0]  OP_ERASE1       = 6'h18;
    localparam logic [5:0]  OP_BULK         = 6'h10;
    localparam logic [3:0]  OP_WRITE_HI     = 4'h1;
    localparam logic [23:0] EE_BASE         = 24'h7FFE00;
    localparam logic [23:0] EE_TOP          = 24'h7FFFFF;
    localparam int          EE_WORDS        = 256;
    localparam logic [15:0] ERASED_WORD     = 16'hFFFF;
    localparam int          ERASE_TIME_US   = 4;
    localparam int          WRITE_TIME_US   = 4;
    localparam int          CLK_MHZ         = 40;
    localparam int          ERASE_CYCLES    = ERASE_TIME_US * CLK_MHZ;
    localparam int          WRITE_CYCLES    = WRITE_TIME_US * CLK_MHZ;
endpackage : eeprom_ctrl_pkg

// ---- verification/cpu_core_model.sv ----
module cpu_core_model (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // entered right after an edge; psel stays up so a setup may follow at once
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        r = prdata;
    endtask : xfer

    task automatic idle();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : idle

    // keys and start go out back to back, nothing between them
    task automatic unlockStart(input logic [15:0] ctrl, input logic [7:0] k1,
                               input logic [7:0] k2);
        logic [31:0] r;
        xfer(1'b1, eeprom_ctrl_pkg::CONTROL_OFFSET, {16'h0000, ctrl}, r);
        xfer(1'b1, eeprom_ctrl_pkg::KEY_OFFSET, {24'h000000, k1}, r);
        xfer(1'b1, eeprom_ctrl_pkg::KEY_OFFSET, {24'h000000, k2}, r);
        xfer(1'b1, eeprom_ctrl_pkg::CONTROL_OFFSET, {16'h0000, ctrl | 16'h8000}, r);
        idle();
    endtask : unlockStart
endmodule : cpu_core_model

// ---- verification/data_eeprom_controller_bench.sv ----
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("[ERR] %0t got %h expected %h", $time, (g), (e)); \
        end \
    end

module data_eeprom_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [31:0] val;
        logic [31:0] mask;
        logic        err;
    } note_s;

    logic        clk;
    logic        rstn;
    logic        pinReset;
    logic        watchdog;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic        memopDoneFlag;
    note_s       noteQ[$];
    note_s       note;
    int          n_fail;
    int          num_checks;
    int          doneCount;
    int          busyLen;
    int          cycles;
    int          lastLen;
    int          autoLen;
    integer      seed;
    logic [15:0] dat[0:8];
    logic [5:0]  eraseCode[0:2];
    int          eraseSize[0:2];

    always #12.5 clk = ~clk;

    data_eeprom_controller #(
        .ERASE_CYCLES(12),
        .WRITE_CYCLES(8)
    ) data_eeprom_controller_i (
        .clk(clk),
        .rstn(rstn),
        .pinReset(pinReset),
        .watchdog(watchdog),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .busy(busy),
        .memopDoneFlag(memopDoneFlag)
    );

    cpu_core_model cpu_core_model_i (
        .clk(clk),
        .pready(pready),
        .prdata(prdata),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize

    always @(posedge clk)
    begin
        cycles++;
        if (memopDoneFlag === 1'b1)
            doneCount++;
        if (busy === 1'b1)
            busyLen++;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
        begin
            note = noteQ.pop_front();
            `CHK(prdata & note.mask, note.val & note.mask)
            `CHK(pslverr, note.err)
        end
        if (cycles == 20000)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        cpu_core_model_i.xfer(1'b1, a, d, r);
        cpu_core_model_i.idle();
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e,
                      input logic [31:0] m, input logic err);
        logic [31:0] r;
        noteQ.push_back('{e, m, err});
        cpu_core_model_i.xfer(1'b0, a, d, r);
        cpu_core_model_i.idle();
    endtask : rd

    function automatic logic [31:0] ea(input int k);
        return {8'h00, eeprom_ctrl_pkg::EE_BASE + 24'(2 * k)};
    endfunction : ea

    task automatic rdWord(input int k, input logic [15:0] e);
        rd(eeprom_ctrl_pkg::TBLRD_OFFSET, ea(k), {16'h0000, e}, 32'h0000FFFF, 1'b0);
    endtask : rdWord

    // host waits for the cycle end before touching the array
    task automatic waitIdle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
    endtask : waitIdle

    // mode 1: a cycle runs; 0: refused; 2: only the start bit is judged
    task automatic runOp(input logic [15:0] c, input logic [7:0] k1, input logic [7:0] k2,
                         input int mode);
        int d0;
        int b0;
        d0 = doneCount;
        b0 = busyLen;
        cpu_core_model_i.unlockStart(c, k1, k2);
        if (mode == 1)
            rd(eeprom_ctrl_pkg::STATUS_OFFSET, 0, 32'h2, 32'h2, 1'b0);
        waitIdle();
        lastLen = busyLen - b0;
        if (mode != 2)
            `CHK(doneCount - d0, mode)
        if (mode == 0)
            `CHK(lastLen, 0)
        rd(eeprom_ctrl_pkg::CONTROL_OFFSET, 0, 0, 32'h8000, 1'b0);
    endtask : runOp

    task automatic writeWord(input int k, input logic [15:0] d, input logic skip);
        wr(eeprom_ctrl_pkg::TBLWR_OFFSET, ea(k));
        wr(eeprom_ctrl_pkg::LATCH_OFFSET, {16'h0000, d});
        runOp(16'h4004 | {3'b000, skip, 12'h000}, 8'h55, 8'hAA, 1);
    endtask : writeWord

    initial
    begin
        clk = 1'b0;
        rstn = 1'b0;
        pinReset = 1'b0;
        watchdog = 1'b0;
        n_fail = 0;
        num_checks = 0;
        doneCount = 0;
        busyLen = 0;
        cycles = 0;
        seed = 20;
        eraseCode = '{eeprom_ctrl_pkg::OP_ERASE8, eeprom_ctrl_pkg::OP_ERASE4,
                      eeprom_ctrl_pkg::OP_ERASE1};
        eraseSize = '{8, 4, 1};
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(eeprom_ctrl_pkg::CONTROL_OFFSET, 0, 0, 32'h0000FFFF, 1'b0);
        wr(eeprom_ctrl_pkg::KEY_OFFSET, 32'h55);
        rd(eeprom_ctrl_pkg::KEY_OFFSET, 0, 0, 32'hFFFFFFFF, 1'b0);
        rd(12'h0FC, 0, 0, 32'hFFFFFFFF, 1'b1);
        runOp(16'h4050, 8'h55, 8'hAA, 1);
        for (int k = 0; k < eeprom_ctrl_pkg::EE_WORDS; k++)
            rdWord(k, eeprom_ctrl_pkg::ERASED_WORD);
        wr(eeprom_ctrl_pkg::TBLWR_OFFSET, 32'h00FFFE11);
        rd(eeprom_ctrl_pkg::ADDR_OFFSET, 0, 32'h007FFE10, 32'h00FFFFFF, 1'b0);
        dat[0] = 16'($random(seed));
        dat[1] = 16'($random(seed));
        writeWord(0, dat[0], 1'b0);
        autoLen = lastLen;
        writeWord(1, dat[1], 1'b1);
        `CHK(lastLen < autoLen, 1'b1)
        rdWord(0, dat[0]);
        rdWord(1, dat[1]);
        for (int i = 0; i < 3; i++)
        begin
            for (int k = 0; k < 9; k++)
            begin
                dat[k] = 16'($random(seed));
                writeWord(k, dat[k], 1'b1);
            end
            wr(eeprom_ctrl_pkg::TBLWR_OFFSET, ea(0));
            runOp(16'h4040 | {10'h000, eraseCode[i]}, 8'h55, 8'hAA, 1);
            for (int k = 0; k < 9; k++)
                rdWord(k, (k < eraseSize[i]) ? eeprom_ctrl_pkg::ERASED_WORD : dat[k]);
        end
        // word 0 is erased now; none of these may touch it
        wr(eeprom_ctrl_pkg::TBLWR_OFFSET, ea(0));
        wr(eeprom_ctrl_pkg::LATCH_OFFSET, 32'h00000000);
        runOp(16'h0004, 8'h55, 8'hAA, 0);
        runOp(16'h4004, 8'hAA, 8'h55, 0);
        runOp(16'h4004, 8'h55, 8'h56, 0);
        runOp(16'h401A, 8'h55, 8'hAA, 2);
        runOp(16'h403F, 8'h55, 8'hAA, 2);
        rdWord(0, eeprom_ctrl_pkg::ERASED_WORD);
        for (int s = 0; s < 2; s++)
        begin
            wr(eeprom_ctrl_pkg::TBLWR_OFFSET, ea(2));
            wr(eeprom_ctrl_pkg::LATCH_OFFSET, 32'h0000A5A5);
            cpu_core_model_i.unlockStart(16'h4004, 8'h55, 8'hAA);
            repeat (3) @(posedge clk);
            pinReset <= (s == 0);
            watchdog <= (s == 1);
            @(posedge clk);
            pinReset <= 1'b0;
            watchdog <= 1'b0;
            waitIdle();
            rd(eeprom_ctrl_pkg::CONTROL_OFFSET, 0, 32'h2000, 32'hA000, 1'b0);
            writeWord(3, 16'h5A5A, 1'b0);
            rd(eeprom_ctrl_pkg::CONTROL_OFFSET, 0, 0, 32'h2000, 1'b0);
        end
        rdWord(3, 16'h5A5A);
        summarize();
    end
endmodule : data_eeprom_controller_bench

// ---- verilog/data_eeprom_controller.sv ----
module data_eeprom_controller #(
    parameter int ERASE_CYCLES = eeprom_ctrl_pkg::ERASE_CYCLES,
    parameter int WRITE_CYCLES = eeprom_ctrl_pkg::WRITE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        pinReset,
    input  wire logic        watchdog,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy,
    output logic             memopDoneFlag
);
    typedef enum logic [1:0] {IDLE, ERASING, PROGRAMMING, CLEARING} state_e;

    state_e      state;
    logic [15:0] control;
    logic [7:0]  capturedAddressUpper;
    logic [15:0] capturedAddressLower;
    logic [15:0] writeLatch;
    logic [15:0] timer;
    logic [7:0]  clearIndex;
    logic [7:0]  clearEnd;
    logic        unlocked;
    logic        memWe;
    logic [7:0]  memWaddr;
    logic [15:0] memWdata;
    logic [15:0] memRdata;
    logic        readPending;

    // apb decode
    wire        access    = psel && penable;
    wire        wrAccess  = access && pwrite;
    wire        rdAccess  = access && !pwrite;
    wire        selCtrl   = paddr == eeprom_ctrl_pkg::CONTROL_OFFSET;
    wire        selKey    = paddr == eeprom_ctrl_pkg::KEY_OFFSET;
    wire        selTblWr  = paddr == eeprom_ctrl_pkg::TBLWR_OFFSET;
    wire        selLatch  = paddr == eeprom_ctrl_pkg::LATCH_OFFSET;
    wire        selTblRd  = paddr == eeprom_ctrl_pkg::TBLRD_OFFSET;
    wire        selAddr   = paddr == eeprom_ctrl_pkg::ADDR_OFFSET;
    wire        selStatus = paddr == eeprom_ctrl_pkg::STATUS_OFFSET;
    wire        mapped    = selCtrl || selKey || selTblWr || selLatch || selTblRd
                            || selAddr || selStatus;
    wire        keyWrite  = wrAccess && selKey;
    // any other access, read or write, closes the key sequence
    wire        otherWrite = access && !keyWrite;
    wire        ctrlWrite = wrAccess && selCtrl;

    // table read: word address 23:1 in ee window
    wire [23:0] readAddr  = {pwdata[23:1], 1'b0};
    wire        readHit   = readAddr >= eeprom_ctrl_pkg::EE_BASE
                            && readAddr <= eeprom_ctrl_pkg::EE_TOP;
    wire [7:0]  readIndex = readAddr[8:1];

    // start decode
    wire        startReq  = ctrlWrite && unlocked && pwdata[eeprom_ctrl_pkg::START_BIT]
                            && pwdata[eeprom_ctrl_pkg::PERMIT_BIT]
                            && control[eeprom_ctrl_pkg::PERMIT_BIT]
                            && state == IDLE;
    wire [5:0]  newOp     = pwdata[5:0];
    wire        newErase  = pwdata[eeprom_ctrl_pkg::ERASE_SEL_BIT];
    wire        isBulk    = newErase && newOp == eeprom_ctrl_pkg::OP_BULK;
    wire        isErase   = newErase && (newOp == eeprom_ctrl_pkg::OP_ERASE8
                            || newOp == eeprom_ctrl_pkg::OP_ERASE4
                            || newOp == eeprom_ctrl_pkg::OP_ERASE1);
    wire        isWrite   = !newErase && newOp[5:2] == eeprom_ctrl_pkg::OP_WRITE_HI;
    wire        skipErase = pwdata[eeprom_ctrl_pkg::SKIP_ERASE_BIT];
    wire [7:0]  wordBase  = capturedAddressLower[8:1];

    function automatic logic [7:0] eraseSpan(input logic [1:0] size);
        case (size)
            2'b10:   eraseSpan = 8'd7;
            2'b01:   eraseSpan = 8'd3;
            default: eraseSpan = 8'd0;
        endcase
    endfunction : eraseSpan

    // sized erase aligns the base to its span
    wire [7:0]  span      = eraseSpan(newOp[1:0]);
    wire [7:0]  alignBase = wordBase & ~span;

    unlock_key keyUnit (
        .clk        (clk),
        .rstn       (rstn),
        .keyWrite   (keyWrite),
        .keyValue   (pwdata[7:0]),
        .otherWrite (otherWrite),
        .unlocked   (unlocked)
    );

    eeprom_array #(
        .WORDS (eeprom_ctrl_pkg::EE_WORDS),
        .AW    (8)
    ) arrayUnit (
        .clk   (clk),
        .we    (memWe),
        .waddr (memWaddr),
        .wdata (memWdata),
        .raddr (readIndex),
        .rdata (memRdata)
    );

    wire cycleAbort = (pinReset || watchdog) && state != IDLE;
    wire timerDone  = timer == 16'd0;

    // program/erase sequencer, runs beside bus traffic
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state         <= IDLE;
            timer         <= 16'd0;
            clearIndex    <= 8'd0;
            clearEnd      <= 8'd0;
            memWe         <= 1'b0;
            memWaddr      <= 8'd0;
            memWdata      <= 16'd0;
            memopDoneFlag <= 1'b0;
        end
        else
        begin
            memWe         <= 1'b0;
            memopDoneFlag <= 1'b0;
            if (cycleAbort)
            begin
                state <= IDLE;
            end
            else
            begin
                case (state)
                    IDLE:
                    begin
                        if (startReq && isBulk)
                        begin
                            clearIndex <= 8'd0;
                            clearEnd   <= 8'hFF;
                            timer      <= 16'(ERASE_CYCLES);
                            state      <= ERASING;
                        end
                        else if (startReq && isErase)
                        begin
                            clearIndex <= alignBase;
                            clearEnd   <= alignBase | span;
                            timer      <= 16'(ERASE_CYCLES);
                            state      <= ERASING;
                        end
                        else if (startReq && isWrite)
                        begin
                            timer <= skipErase ? 16'(WRITE_CYCLES)
                                               : 16'(WRITE_CYCLES + ERASE_CYCLES);
                            state <= PROGRAMMING;
                        end
                        else if (startReq)
                        begin
                            state <= CLEARING;
                        end
                    end
                    ERASING:
                    begin
                        if (timerDone)
                        begin
                            memWe      <= 1'b1;
                            memWaddr   <= clearIndex;
                            memWdata   <= eeprom_ctrl_pkg::ERASED_WORD;
                            clearIndex <= clearIndex + 8'd1;
                            if (clearIndex == clearEnd)
                            begin
                                memopDoneFlag <= 1'b1;
                                state         <= IDLE;
                            end
                        end
                        else
                        begin
                            timer <= timer - 16'd1;
                        end
                    end
                    PROGRAMMING:
                    begin
                        if (timerDone)
                        begin
                            memWe         <= 1'b1;
                            memWaddr      <= wordBase;
                            memWdata      <= writeLatch;
                            memopDoneFlag <= 1'b1;
                            state         <= IDLE;
                        end
                        else
                        begin
                            timer <= timer - 16'd1;
                        end
                    end
                    default:
                    begin
                        state <= IDLE;
                    end
                endcase
            end
        end
    end

    wire cycleEnd = state != IDLE && (cycleAbort || state == CLEARING
                    || (timerDone && (state == PROGRAMMING
                    || (state == ERASING && clearIndex == clearEnd))));

    // control register
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            control <= eeprom_ctrl_pkg::CONTROL_RESET;
            busy    <= 1'b0;
        end
        else
        begin
            if (ctrlWrite && state == IDLE)
            begin
                control[11:0] <= pwdata[11:0] & eeprom_ctrl_pkg::CONTROL_WMASK[11:0];
                control[eeprom_ctrl_pkg::SKIP_ERASE_BIT] <=
                    pwdata[eeprom_ctrl_pkg::SKIP_ERASE_BIT];
                control[eeprom_ctrl_pkg::PERMIT_BIT] <= pwdata[eeprom_ctrl_pkg::PERMIT_BIT];
            end
            if (startReq)
            begin
                control[eeprom_ctrl_pkg::START_BIT] <= 1'b1;
                busy <= 1'b1;
            end
            else if (cycleEnd)
            begin
                control[eeprom_ctrl_pkg::START_BIT] <= 1'b0;
                busy <= 1'b0;
            end
            if (cycleAbort)
            begin
                control[eeprom_ctrl_pkg::ABORT_BIT] <= 1'b1;
            end
            else if (memopDoneFlag)
            begin
                control[eeprom_ctrl_pkg::ABORT_BIT] <= 1'b0;
            end
        end
    end

    // table write captures address, latch write captures data
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            capturedAddressUpper <= 8'h00;
            capturedAddressLower <= 16'h0000;
            writeLatch           <= 16'h0000;
        end
        else if (wrAccess && selTblWr)
        begin
            capturedAddressUpper <= {1'b0, pwdata[22:16]};
            capturedAddressLower <= {pwdata[15:1], 1'b0};
        end
        else if (wrAccess && selLatch)
        begin
            writeLatch <= pwdata[15:0];
        end
    end

    // apb answer: reads of the table port take two extra cycles
    wire        needWait = rdAccess && selTblRd && !readPending;
    wire [31:0] rdMux    = selCtrl  ? {16'h0000, control}
                         : selTblRd ? {16'h0000, readHit ? memRdata : 16'h0000}
                         : selLatch ? {16'h0000, writeLatch}
                         : selAddr  ? {8'h00, capturedAddressUpper, capturedAddressLower}
                         : selStatus ? {30'd0, busy, unlocked}
                         : 32'd0;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            readPending <= 1'b0;
            pready      <= 1'b0;
            prdata      <= 32'd0;
            pslverr     <= 1'b0;
        end
        else
        begin
            readPending <= needWait;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            if (psel && !penable)
            begin
                pready  <= !(!pwrite && selTblRd);
                pslverr <= !mapped;
                prdata  <= pwrite ? 32'd0 : rdMux;
            end
            else if (readPending)
            begin
                pready <= 1'b1;
                prdata <= rdMux;
            end
        end
    end

    start_needs_key_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(busy) |-> $past(unlocked))
        else $error("cycle started without unlock");
    abort_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        cycleAbort |=> control[eeprom_ctrl_pkg::ABORT_BIT] && !busy)
        else $error("abort not flagged");
    done_clears_start_a: assert property (@(posedge clk) disable iff (!rstn)
        memopDoneFlag |-> !control[eeprom_ctrl_pkg::START_BIT] && !busy)
        else $error("done without start clear");
    nop_code_a: assert property (@(posedge clk) disable iff (!rstn)
        state == CLEARING |=> !busy && !memWe)
        else $error("unknown code altered array");
endmodule : data_eeprom_controller

// ---- verilog/eeprom_array.sv ----
module eeprom_array #(
    parameter int WORDS = 256,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [15:0]   wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [15:0]   rdata
);
    logic [15:0] mem [WORDS];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : eeprom_array

// ---- verilog/unlock_key.sv ----
module unlock_key (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       keyWrite,
    input  wire logic [7:0] keyValue,
    input  wire logic       otherWrite,
    output logic            unlocked
);
    logic armed;
    wire  firstKey  = keyWrite && keyValue == eeprom_ctrl_pkg::KEY_FIRST;
    wire  secondKey = keyWrite && keyValue == eeprom_ctrl_pkg::KEY_SECOND && armed;
    // each step lives until the next bus access, so back-to-back transfers chain
    wire  anyAccess = keyWrite || otherWrite;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            armed    <= 1'b0;
            unlocked <= 1'b0;
        end
        else
        begin
            armed    <= firstKey || (armed && !anyAccess);
            unlocked <= secondKey || (unlocked && !anyAccess);
        end
    end

    unlock_window_a: assert property (@(posedge clk) disable iff (!rstn)
        unlocked && anyAccess |=> !unlocked)
        else $error("unlock window outlived next access");
    unlock_order_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(unlocked) |-> $past(keyWrite) && $past(keyValue) == eeprom_ctrl_pkg::KEY_SECOND
            && $past(armed))
        else $error("unlock without ordered keys");
endmodule : unlock_key
